// ==== sflash_array.sv ====
// Array stand-in: returns a data byte for an address, combinational.
// Assumes the main block registers the result before it reaches a pin.
`timescale 1ns/100ps
`default_nettype none
module sflash_array (
  input wire logic [23:0] ADDR_IN,
  output logic [7:0] DATA_OUT
);
  // Pattern from address bytes; a real array macro replaces this
  assign DATA_OUT = ADDR_IN[7:0] ^ ADDR_IN[15:8] ^ ADDR_IN[23:16];
endmodule : sflash_array
`default_nettype wire

// ==== sflash_cfg.svh ====
// Constants for the serial flash status and read command logic.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SFLASH_CFG_SVH
`define SFLASH_CFG_SVH
`define OP_STATUS_WRITE 8'h01
`define OP_READ 8'h03
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_LATCH_SET 8'h06
`define OP_FAST_READ 8'h0b
`define OP_DUAL_READ 8'h3b
`define ADDR_W 24
`define ADDR_BYTES 3'h3
`define BIT_LOCK 7
`define BIT_ZERO6 6
`define BIT_LATCH 1
`define BIT_BUSY 0
`define WRITE_MASK 8'hbc
`define STATUS_RESET 8'h00
`define STATUS_WRITE_TIME_NS 40000
`define CLK_PERIOD_NS 8
`define STATUS_WRITE_CYCLES (`STATUS_WRITE_TIME_NS / `CLK_PERIOD_NS)
`define BITS_PER_BYTE 4'h8
`define DUMMY_CLOCKS 4'h8
`endif

// ==== sflash_host.sv ====
// Host model for the serial flash block: drives select, serial clock and
// serial input, and samples both data lines. Assumes mode 0 framing.
`timescale 1ns/100ps
`default_nettype none
module sflash_host (
  output var logic sel_n_out,
  output var logic sclk_out,
  output var logic si_out,
  input wire logic hi_in,
  input wire logic hi_oe_in,
  input wire logic lo_in,
  input wire logic lo_oe_in
);
  logic hi_last;
  logic lo_last;
  // Idle levels: clock stands still low outside frames
  initial
  begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
    hi_last = 1'b0;
    lo_last = 1'b0;
  end
  // ------------------------------------------------------------
  // Frame tasks, 125 ns serial clock
  // ------------------------------------------------------------
  task automatic open_frame();
    sel_n_out = 1'b0;
    #62.5;
  endtask : open_frame
  // Bits go out MSB first, set up mid-way through the low half
  task automatic send(input logic [7:0] b, input int nbits);
    for (int i = 0; i < nbits; i++)
    begin
      si_out = b[7 - i];
      #31.3 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
      #31.2;
    end
  endtask : send
  // A released line reads as the inverse of its last level, so a
  // missing drive never passes as data
  task automatic recv(input bit dual, output logic [7:0] b);
    logic h;
    logic l;
    b = 8'h00;
    for (int i = 0; i < (dual ? 4 : 8); i++)
    begin
      #31.3 sclk_out = 1'b1;
      h = hi_oe_in ? hi_in : ~hi_last;
      l = lo_oe_in ? lo_in : ~lo_last;
      hi_last = h;
      lo_last = l;
      b = dual ? {b[5:0], h, l} : {b[6:0], h};
      #62.5 sclk_out = 1'b0;
      #31.2;
    end
  endtask : recv
  // Select rises after the last fall, on or off a byte boundary
  task automatic close_frame();
    #31.25 sel_n_out = 1'b1;
    #500;
  endtask : close_frame
endmodule : sflash_host
`default_nettype wire

// ==== sflash_pkg.sv ====
// Types for the serial flash command logic.
// Assumes the constants header is present in the same folder.
`include "sflash_cfg.svh"
package sflash_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA_OUT,
    ST_STATUS_OUT,
    ST_STATUS_IN,
    ST_IGNORE
  } phase_e;
  typedef enum logic [1:0] {
    RD_NORMAL,
    RD_FAST,
    RD_DUAL
  } read_kind_e;
endpackage : sflash_pkg

// ==== sflash_status_read.sv ====
// Serial flash command logic: status register, status write with lock
// modes, and the normal, dummy-byte and dual-output array reads.
// Assumes host pins are asynchronous to SYS_CLK_IN and SCLK is far slower.
`timescale 1ns/100ps
`default_nettype none
`include "sflash_cfg.svh"
module sflash_status_read (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic SEL_N_IN,
  input wire logic SCLK_IN,
  input wire logic SI_IN,
  input wire logic WP_N_IN,
  output logic DUAL_LINE_LOW_OUT,
  output logic DUAL_LINE_LOW_OE_OUT,
  output logic DUAL_LINE_HIGH_OUT,
  output logic DUAL_LINE_HIGH_OE_OUT,
  output logic [7:0] STATUS_OUT,
  output logic HARDWARE_LOCK_MODE_OUT,
  output logic [3:0] PROTECT_LEVEL_OUT
);
  parameter int STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sel_n_s_q, sclk_s_q, si_s_q, wp_n_s_q;
  logic sclk_prev_q, sel_prev_q;
  // Two stages each; only the second stage is read by logic
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      sel_n_s_q <= 2'h3;
      sclk_s_q <= 2'h0;
      si_s_q <= 2'h0;
      wp_n_s_q <= 2'h3;
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end
    else if (CLK_EN_IN)
    begin
      sel_n_s_q <= {sel_n_s_q[0], SEL_N_IN};
      sclk_s_q <= {sclk_s_q[0], SCLK_IN};
      si_s_q <= {si_s_q[0], SI_IN};
      wp_n_s_q <= {wp_n_s_q[0], WP_N_IN};
      sclk_prev_q <= sclk_s_q[1];
      sel_prev_q <= sel_n_s_q[1];
    end

  logic sel_n, sclk_rise, sclk_fall, sel_rise, wp_n;
  assign sel_n = sel_n_s_q[1];
  assign wp_n = wp_n_s_q[1];
  assign sclk_rise = CLK_EN_IN & ~sel_n & sclk_s_q[1] & ~sclk_prev_q;
  assign sclk_fall = CLK_EN_IN & ~sel_n & ~sclk_s_q[1] & sclk_prev_q;
  assign sel_rise = CLK_EN_IN & sel_n & ~sel_prev_q;

  // ----------------------------------------------------------------
  // Command shifter
  // ----------------------------------------------------------------
  sflash_pkg::phase_e phase_q;
  sflash_pkg::read_kind_e kind_q;
  logic [7:0] shift_q, opcode_q, wr_data_q, out_q, status_q, array_byte, shift_next;
  logic [3:0] bit_cnt_q, out_cnt_q;
  logic [2:0] byte_cnt_q;
  logic [`ADDR_W-1:0] addr_q;
  logic [31:0] busy_cnt_q;
  logic wr_armed_q, busy_q, hw_lock_q, byte_done, out_byte_end, start_write;
  logic dual_q, drive_q;

  assign shift_next = {shift_q[6:0], si_s_q[1]};
  assign byte_done = sclk_rise && (bit_cnt_q == `BITS_PER_BYTE - 4'h1);

  // Status write allowed only with latch and outside hardware lock
  function automatic logic write_allowed(input logic [7:0] st, input logic lock);
    write_allowed = st[`BIT_LATCH] & ~lock;
  endfunction : write_allowed

  sflash_array array_u (
    .ADDR_IN(addr_q),
    .DATA_OUT(array_byte)
  );

  // Bit counter restarts at each select, counts rising edges per byte
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end
    else if (CLK_EN_IN)
    begin
      if (sel_n)
        bit_cnt_q <= 4'h0;
      else if (sclk_rise)
      begin
        shift_q <= shift_next;
        bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_q + 4'h1;
      end
    end

  // Phase machine; opcode decode happens at the eighth rising edge
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      phase_q <= sflash_pkg::ST_OPCODE;
      kind_q <= sflash_pkg::RD_NORMAL;
      opcode_q <= 8'h00;
      byte_cnt_q <= 3'h0;
      wr_data_q <= 8'h00;
      wr_armed_q <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      if (sel_n)
      begin
        phase_q <= sflash_pkg::ST_OPCODE;
        byte_cnt_q <= 3'h0;
        if (!sel_rise)
          wr_armed_q <= 1'b0;
      end
      else if (sclk_rise)
      begin
        // Any extra edge after the data byte breaks the byte boundary
        if (wr_armed_q && bit_cnt_q == 4'h0)
          wr_armed_q <= 1'b0;
        case (phase_q)
          sflash_pkg::ST_OPCODE:
            if (byte_done)
            begin
              opcode_q <= shift_next;
              byte_cnt_q <= 3'h0;
              kind_q <= (shift_next == `OP_DUAL_READ) ? sflash_pkg::RD_DUAL :
                (shift_next == `OP_FAST_READ) ? sflash_pkg::RD_FAST : sflash_pkg::RD_NORMAL;
              case (shift_next)
                `OP_READ:
                  phase_q <= sflash_pkg::ST_ADDR;
                `OP_FAST_READ, `OP_DUAL_READ:
                  // Busy rejects without touching the running cycle
                  phase_q <= busy_q ? sflash_pkg::ST_IGNORE : sflash_pkg::ST_ADDR;
                `OP_STATUS_READ:
                  phase_q <= sflash_pkg::ST_STATUS_OUT;
                `OP_STATUS_WRITE:
                  phase_q <= sflash_pkg::ST_STATUS_IN;
                default:
                  phase_q <= sflash_pkg::ST_IGNORE;
              endcase
            end
          sflash_pkg::ST_ADDR:
            if (byte_done)
            begin
              byte_cnt_q <= byte_cnt_q + 3'h1;
              if (byte_cnt_q == `ADDR_BYTES - 3'h1)
                phase_q <= (kind_q == sflash_pkg::RD_NORMAL) ?
                  sflash_pkg::ST_DATA_OUT : sflash_pkg::ST_DUMMY;
            end
          sflash_pkg::ST_DUMMY:
            if (byte_done)
              phase_q <= sflash_pkg::ST_DATA_OUT;
          sflash_pkg::ST_STATUS_IN:
            if (byte_done)
            begin
              wr_data_q <= shift_next;
              wr_armed_q <= 1'b1;
              phase_q <= sflash_pkg::ST_IGNORE;
            end
          default: ;
        endcase
      end
    end

  // Address load on rising edges, advance as each output byte is loaded
  assign out_byte_end = sclk_fall && phase_q == sflash_pkg::ST_DATA_OUT &&
    out_cnt_q == 4'h0;
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      addr_q <= 24'h000000;
    else if (sclk_rise && phase_q == sflash_pkg::ST_ADDR)
      addr_q <= {addr_q[22:0], si_s_q[1]};
    else if (out_byte_end)
      addr_q <= addr_q + 24'h000001; // natural wrap to zero

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  // Bits shift on falling edges; dual mode moves two per edge
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      out_q <= 8'h00;
      out_cnt_q <= 4'h0;
      dual_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      if (sel_n)
      begin
        drive_q <= 1'b0;
        dual_q <= 1'b0;
        out_cnt_q <= 4'h0;
      end
      else if (sclk_fall && (phase_q == sflash_pkg::ST_DATA_OUT ||
        phase_q == sflash_pkg::ST_STATUS_OUT))
      begin
        drive_q <= 1'b1;
        // Two-line only for dual array data
        dual_q <= phase_q == sflash_pkg::ST_DATA_OUT &&
          kind_q == sflash_pkg::RD_DUAL;
        if (out_cnt_q == 4'h0)
        begin
          out_q <= (phase_q == sflash_pkg::ST_STATUS_OUT) ?
            {status_q[7:1], busy_q} : array_byte; // live busy in polls
          out_cnt_q <= (phase_q == sflash_pkg::ST_DATA_OUT &&
            kind_q == sflash_pkg::RD_DUAL) ? 4'h3 : 4'h7;
        end
        else
        begin
          out_q <= dual_q ? {out_q[5:0], 2'b00} : {out_q[6:0], 1'b0};
          out_cnt_q <= out_cnt_q - 4'h1;
        end
      end
    end

  // Single mode drives the high line only; dual drives both
  assign DUAL_LINE_HIGH_OUT = out_q[7];
  assign DUAL_LINE_HIGH_OE_OUT = drive_q;
  assign DUAL_LINE_LOW_OUT = dual_q ? out_q[6] : 1'b0;
  assign DUAL_LINE_LOW_OE_OUT = drive_q & dual_q;

  // ----------------------------------------------------------------
  // Status register and protection
  // ----------------------------------------------------------------
  // Select must rise with the counter right on a boundary
  assign start_write = sel_rise && wr_armed_q && bit_cnt_q == 4'h0 &&
    opcode_q == `OP_STATUS_WRITE && write_allowed(status_q, hw_lock_q);

  // Hardware lock follows pin and lock bit whichever arrives last
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      hw_lock_q <= 1'b0;
    else if (CLK_EN_IN && wp_n)
      hw_lock_q <= 1'b0;
    else if (CLK_EN_IN && status_q[`BIT_LOCK])
      hw_lock_q <= 1'b1;

  // Busy counter models the self-timed write cycle
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= 32'h0;
    end
    else if (CLK_EN_IN)
    begin
      if (start_write)
      begin
        busy_q <= 1'b1;
        busy_cnt_q <= 32'(STATUS_WRITE_CYCLES - 1);
      end
      else if (busy_q && busy_cnt_q == 32'h0)
        busy_q <= 1'b0;
      else if (busy_q)
        busy_cnt_q <= busy_cnt_q - 32'h1;
    end

  // Protect and lock bits commit at end of cycle; latch cleared too
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      status_q <= `STATUS_RESET;
    else if (CLK_EN_IN)
    begin
      if (busy_q && busy_cnt_q == 32'h0)
      begin
        status_q <= (wr_data_q & `WRITE_MASK) | (status_q & ~`WRITE_MASK);
        status_q[`BIT_LATCH] <= 1'b0;
      end
      else if (sel_rise && bit_cnt_q == 4'h0 && phase_q == sflash_pkg::ST_IGNORE && !busy_q &&
        (opcode_q == `OP_LATCH_SET || opcode_q == `OP_LATCH_CLEAR))
        status_q[`BIT_LATCH] <= opcode_q == `OP_LATCH_SET;
      status_q[`BIT_ZERO6] <= 1'b0;
    end

  // Busy reflected live into every status read
  assign STATUS_OUT = {status_q[7:1], busy_q};
  assign HARDWARE_LOCK_MODE_OUT = hw_lock_q;
  // Program and erase logic elsewhere gates on these levels
  assign PROTECT_LEVEL_OUT = status_q[5:2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_write_needs_latch: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    start_write |-> status_q[`BIT_LATCH]) else $error("write without latch");
  a_hw_lock_blocks: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    hw_lock_q |-> !start_write) else $error("write in hardware lock");
  a_busy_starts: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    start_write && CLK_EN_IN |=> busy_q) else $error("busy not set");
  a_lock_leaves: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    hw_lock_q && wp_n && CLK_EN_IN |=> !hw_lock_q) else $error("lock stuck");
  a_bit6_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(busy_q) |=> STATUS_OUT[`BIT_ZERO6] == 1'b0) else $error("bit6 set");
  a_stop_drive: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    sel_n && CLK_EN_IN |=> !DUAL_LINE_HIGH_OE_OUT) else $error("drive after select");
  a_dual_only_data: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    DUAL_LINE_LOW_OE_OUT |-> kind_q == sflash_pkg::RD_DUAL) else $error("dual misuse");
  a_busy_reject: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    byte_done && phase_q == sflash_pkg::ST_OPCODE && busy_q &&
    shift_next == `OP_FAST_READ |=> phase_q == sflash_pkg::ST_IGNORE)
    else $error("fast read while busy");
  c_status_write: cover property (@(posedge SYS_CLK_IN) start_write);
  c_dual_out: cover property (@(posedge SYS_CLK_IN) DUAL_LINE_LOW_OE_OUT);
  c_hw_lock: cover property (@(posedge SYS_CLK_IN) $rose(hw_lock_q));
endmodule : sflash_status_read
`default_nettype wire

// ==== test_sflash_status_read.sv ====
// Self-checking bench for the serial flash status and read logic.
// Assumes the host model above and a shortened status write time.
`timescale 1ns/100ps
`default_nettype none
`include "sflash_cfg.svh"
module test_sflash_status_read;
  // Long enough to poll busy and send two rejected reads over the link
  localparam int WR_CYC = 2500;
  logic clk;
  logic rst;
  logic wp_n;
  logic en;
  logic sel_n, sclk, si, hi, hi_oe, lo, lo_oe, hwl;
  logic [7:0] st;
  logic [3:0] pl;
  logic [7:0] s0, s1, d0, d1, e0, e1;
  logic [23:0] a;
  logic seen_h, seen_l;
  int n_fail = 0;
  int tests_run = 0;
  int seed = 32'hedce4d6f;
  sflash_status_read #(.STATUS_WRITE_CYCLES(WR_CYC)) dut (.SYS_CLK_IN(clk), .RST_IN(rst),
    .CLK_EN_IN(en), .SEL_N_IN(sel_n), .SCLK_IN(sclk), .SI_IN(si), .WP_N_IN(wp_n),
    .DUAL_LINE_LOW_OUT(lo), .DUAL_LINE_LOW_OE_OUT(lo_oe), .DUAL_LINE_HIGH_OUT(hi),
    .DUAL_LINE_HIGH_OE_OUT(hi_oe), .STATUS_OUT(st), .HARDWARE_LOCK_MODE_OUT(hwl),
    .PROTECT_LEVEL_OUT(pl));
  sflash_host host (.sel_n_out(sel_n), .sclk_out(sclk), .si_out(si), .hi_in(hi),
    .hi_oe_in(hi_oe), .lo_in(lo), .lo_oe_in(lo_oe));
  // Clock and drive tracking per frame
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (hi_oe === 1'b1) seen_h = 1'b1;
    if (lo_oe === 1'b1) seen_l = 1'b1;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] after_write(input logic [7:0] d);
    return d & `WRITE_MASK; // Busy and latch end at zero, bit six fixed
  endfunction : after_write
  // Array stand-in contents: the three address bytes folded together
  function automatic logic [7:0] exp_byte(input logic [23:0] ad);
    return ad[7:0] ^ ad[15:8] ^ ad[23:16];
  endfunction : exp_byte
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    host.send(op, 8);
    host.close_frame();
  endtask : cmd
  task automatic wr_status(input logic [7:0] d, input bit extra);
    host.open_frame();
    host.send(`OP_STATUS_WRITE, 8);
    host.send(d, 8);
    if (extra) host.send(8'h00, 1); // Off the byte boundary
    host.close_frame();
  endtask : wr_status
  task automatic rd_status(output logic [7:0] r0, output logic [7:0] r1);
    seen_l = 1'b0;
    host.open_frame();
    host.send(`OP_STATUS_READ, 8);
    host.recv(1'b0, r0);
    host.recv(1'b0, r1);
    host.close_frame();
  endtask : rd_status
  task automatic rd(input logic [7:0] op, input logic [23:0] ad, output logic [7:0] r0,
      output logic [7:0] r1);
    seen_h = 1'b0;
    seen_l = 1'b0;
    host.open_frame();
    host.send(op, 8);
    host.send(ad[23:16], 8);
    host.send(ad[15:8], 8);
    host.send(ad[7:0], 8);
    if (op != `OP_READ) host.send(8'h00, 8); // Dummy byte or dummy clocks
    host.recv(op == `OP_DUAL_READ, r0);
    host.recv(op == `OP_DUAL_READ, r1);
    host.close_frame();
  endtask : rd
  task automatic wait_idle();
    for (int i = 0; i < 3 * WR_CYC && st[0] !== 1'b0; i++) @(posedge clk);
    @(negedge clk);
  endtask : wait_idle
  // Pin change made while the enable is low must wait until it returns
  task automatic set_wp(input logic v);
    logic h;
    @(negedge clk) en = 1'b0;
    h = hwl;
    wp_n = v;
    repeat (8) @(negedge clk);
    chk("frozen lock", {7'h00, h}, {7'h00, hwl});
    en = 1'b1;
    repeat (8) @(negedge clk);
  endtask : set_wp
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Watchdog well beyond the expected run of about 250 us
  initial
  begin
    #600000;
    n_fail++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    wp_n = 1'b1;
    en = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("reset status", 8'h00, st);
    rd_status(s0, s1);
    chk("status read", 8'h00, s0);
    wr_status(8'h3c, 1'b0);
    wait_idle();
    chk("write no latch", 8'h00, st);
    $display("test protection basics done");
    cmd(`OP_LATCH_SET);
    chk("latch set", 8'h02, st);
    cmd(`OP_LATCH_CLEAR);
    chk("latch clear", 8'h00, st);
    cmd(`OP_LATCH_SET);
    wr_status(8'h7f, 1'b0);
    chk("busy at start", 8'h01, st & 8'h01);
    rd_status(s0, s1);
    chk("busy polled", 8'h01, s0 & s1 & 8'h01);
    chk("status single line", 8'h00, {7'h00, seen_l});
    wait_idle();
    chk("write result", after_write(8'h7f), st);
    chk("protect level", 8'h0f, {4'h0, pl});
    cmd(`OP_LATCH_SET);
    wr_status(8'hbc, 1'b0);
    rd(`OP_FAST_READ, 24'h000000, d0, d1);
    chk("fast read busy", 8'h00, {7'h00, seen_h});
    rd(`OP_DUAL_READ, 24'h000000, d0, d1);
    chk("dual read busy", 8'h00, {7'h00, seen_h | seen_l});
    wait_idle();
    chk("write undisturbed", after_write(8'hbc), st);
    $display("test status write done");
    set_wp(1'b0);
    chk("lock entered", 8'h01, {7'h00, hwl});
    cmd(`OP_LATCH_SET);
    wr_status(8'h00, 1'b0);
    wait_idle();
    chk("locked write", 8'hbc, st & 8'hfc);
    set_wp(1'b1);
    chk("lock left", 8'h00, {7'h00, hwl});
    cmd(`OP_LATCH_SET);
    wr_status(8'h00, 1'b0);
    wait_idle();
    chk("pin high write", 8'h00, st);
    set_wp(1'b0);
    chk("no lock bit", 8'h00, {7'h00, hwl});
    cmd(`OP_LATCH_SET);
    wr_status(8'h84, 1'b0);
    wait_idle();
    chk("pin low write", 8'h84, st);
    chk("lock other order", 8'h01, {7'h00, hwl});
    set_wp(1'b1);
    cmd(`OP_LATCH_SET);
    wr_status(8'h00, 1'b1);
    wait_idle();
    chk("off boundary", 8'h84, st & 8'hfc);
    $display("test lock modes done");
    for (int k = 0; k < 5; k++)
    begin
      a = (k == 0) ? 24'hffffff : 24'($random(seed));
      rd(`OP_READ, a, d0, d1);
      chk("normal byte0", exp_byte(a), d0);
      chk("normal byte1", exp_byte(a + 24'h000001), d1);
      chk("normal one line", 8'h00, {7'h00, seen_l});
      chk("drive released", 8'h00, {7'h00, hi_oe});
      rd(`OP_READ, a + 24'h000001, e0, e1);
      chk("next address", d1, e0);
      rd(`OP_FAST_READ, a, e0, e1);
      chk("fast byte0", d0, e0);
      chk("fast byte1", d1, e1);
      rd(`OP_DUAL_READ, a, e0, e1);
      chk("dual byte0", d0, e0);
      chk("dual byte1", d1, e1);
      chk("dual low line", 8'h01, {7'h00, seen_l});
      chk("dual released", 8'h00, {6'h00, hi_oe, lo_oe});
    end
    $display("test array reads done");
    wrap_up();
  end
endmodule : test_sflash_status_read
`default_nettype wire
